// >>> dv/supply_monitor_reset_ctrl_tb.sv
// Purpose: Self-checking bench for the supply monitor
// Assumes: Partner drives comparators and wait instructions
// Notes:   Reads are scored through a queue by a monitor
`timescale 1ns/1ps
module supply_monitor_reset_ctrl_tb
	import supply_monitor_pkg::*;
;
	logic aclk = 1'b0;
	logic aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, brownout_threshold, brownout_level, regulator_state;
	logic rtc_match, wake_request, slow_rc_clk_en, low_xtal_clk_en, high_xtal_clk_en;
	logic low_volt_detect_en, over_volt_detect_en, over_volt_threshold_sel;
	logic [2:0] low_volt_threshold_sel;
	logic low_volt_flag, over_volt_flag, low_volt_irq_line, over_volt_irq_line;
	logic power_reset, brownout_reset, backup_reset, core_reset, rtc_clk_en, wakeup, irq;
	logic wfi_go, wfe_go, wait_for_irq_instr, wait_for_event_instr;
	comp_t want, comp_async;
	pmode_t power_mode;
	int fail_count, compares, cnt;
	logic [33:0] rq[$];
	logic [31:0] r;

	supply_partner partner (.aclk(aclk), .want(want), .wfi_go(wfi_go), .wfe_go(wfe_go),
		.comp_async(comp_async), .wait_for_irq_instr(wait_for_irq_instr),
		.wait_for_event_instr(wait_for_event_instr));

	supply_monitor_reset_ctrl uut (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .comp_async(comp_async),
		.brownout_threshold(brownout_threshold), .rtc_match(rtc_match),
		.wait_for_irq_instr(wait_for_irq_instr), .wait_for_event_instr(wait_for_event_instr),
		.wake_request(wake_request), .slow_rc_clk_en(slow_rc_clk_en),
		.low_xtal_clk_en(low_xtal_clk_en), .high_xtal_clk_en(high_xtal_clk_en),
		.low_volt_detect_en(low_volt_detect_en), .low_volt_threshold_sel(low_volt_threshold_sel),
		.over_volt_detect_en(over_volt_detect_en),
		.over_volt_threshold_sel(over_volt_threshold_sel), .brownout_level(brownout_level),
		.low_volt_flag(low_volt_flag), .over_volt_flag(over_volt_flag),
		.low_volt_irq_line(low_volt_irq_line), .over_volt_irq_line(over_volt_irq_line),
		.power_reset(power_reset), .brownout_reset(brownout_reset), .backup_reset(backup_reset),
		.core_reset(core_reset), .regulator_state(regulator_state), .rtc_clk_en(rtc_clk_en),
		.wakeup(wakeup), .power_mode(power_mode), .irq(irq));

	// ==========================================================
	// Checking
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		compares++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic tally_and_finish();
		$display("mismatches %0d comparisons %0d", fail_count, compares);
		if (fail_count == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : tally_and_finish

	function automatic logic pick(input int s);
		case (s)
			0: return low_volt_flag;
			1: return over_volt_flag;
			2: return irq;
			3: return low_volt_irq_line;
			4: return over_volt_irq_line;
			5: return wakeup;
			6: return power_reset;
			7: return brownout_reset;
			8: return core_reset;
			default: return power_mode === pmode_t'(2'(s - 9));
		endcase
	endfunction : pick

	// Pulses last one cycle, so the poll looks at every edge
	task automatic wait_for(input int s, input logic v);
		int n;
		for (n = 0; n < 400 && pick(s) !== v; n++) @(posedge aclk);
		chk(pick(s), v);
		if (pick(s) !== v) tally_and_finish();
	endtask : wait_for

	// Read scoreboard: oldest expectation against each accepted beat
	always @(posedge aclk)
		if (s_axi_rvalid && s_axi_rready) begin
			if (rq.size() == 0) chk(1, 0);
			else chk({s_axi_rresp, s_axi_rdata}, rq.pop_front());
		end

	// ==========================================================
	// AXI4-Lite master
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		bit b;
		@(posedge aclk);
		b = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (n = 0; n < 100 && !b; n++) begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid && s_axi_bready) begin
				b = 1;
				chk(s_axi_bresp, RESP_OKAY);
				s_axi_bready <= 1'b0;
			end
		end
		if (!b) begin
			chk(0, 1);
			tally_and_finish();
		end
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] rs);
		int n;
		bit b;
		@(posedge aclk);
		b = 0;
		rq.push_back({rs, d});
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (n = 0; n < 100 && !b; n++) begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid && s_axi_rready) begin
				b = 1;
				s_axi_rready <= 1'b0;
			end
		end
		if (!b) begin
			chk(0, 1);
			tally_and_finish();
		end
	endtask : rd

	task automatic core(input bit e);
		@(posedge aclk);
		if (e) wfe_go <= 1'b1;
		else wfi_go <= 1'b1;
		@(posedge aclk);
		wfe_go <= 1'b0;
		wfi_go <= 1'b0;
	endtask : core

	always #12.5 aclk = ~aclk;

	// ==========================================================
	// Scenarios
	initial begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
		{s_axi_rready, rtc_match, wake_request, slow_rc_clk_en, low_xtal_clk_en} = '0;
		{high_xtal_clk_en, wfi_go, wfe_go, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{want, brownout_threshold, fail_count, compares} = '0;
		s_axi_wstrb = 4'hf;
		void'($urandom(32'h5f14));
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		wait_for(8, 0);
		rd(CTRL_OFFSET, 32'h0, RESP_OKAY);
		chk(regulator_state, REG_FULL);
		for (int i = 0; i < 8; i++) begin
			r = 32'h1 | (i << LVD_TH_LSB) | ((i & 1) << OVD_TH_BIT);
			wr(CTRL_OFFSET, r);
			rd(CTRL_OFFSET, r, RESP_OKAY);
			chk(low_volt_threshold_sel, i[2:0]);
			chk(over_volt_threshold_sel, i[0]);
		end
		r = $urandom & 32'hf3f;
		wr(CTRL_OFFSET, r);
		rd(CTRL_OFFSET, r, RESP_OKAY);
		chk({low_volt_detect_en, over_volt_detect_en}, {r[0], r[4]});
		rd(8'h3c, 32'h0, RESP_SLVERR);
		wr(CTRL_OFFSET, 32'h0);
		want.lvd_below <= 1'b1;
		repeat (8) @(posedge aclk);
		chk(low_volt_flag, 1'b0);
		want.lvd_below <= 1'b0;
		wr(EDGE_OFFSET, 32'h33);
		rd(EDGE_OFFSET, 32'h33, RESP_OKAY);
		wr(IRQ_EN_OFFSET, 32'h7);
		rd(IRQ_EN_OFFSET, 32'h7, RESP_OKAY);
		wr(CTRL_OFFSET, 32'h11);
		repeat (8) @(posedge aclk);
		for (int k = 0; k < 2; k++) begin
			want[1-k] <= 1'b1;
			// Third edge: a single-stage path would already show the flag
			repeat (3) @(posedge aclk);
			chk(pick(k), 1'b0);
			wait_for(3 + k, 1);
			wait_for(k, 1);
			rd(STATUS_OFFSET, 32'h1 << k, RESP_OKAY);
			wait_for(2, 1);
			rd(IRQ_ST_OFFSET, 32'h1 << k, RESP_OKAY);
			wr(IRQ_ST_OFFSET, 32'h1 << k);
			wait_for(2, 0);
			want[1-k] <= 1'b0;
			wait_for(3 + k, 1);
			wait_for(k, 0);
			wr(IRQ_ST_OFFSET, 32'h1 << k);
		end
		// Masked event stays pending and fires once unmasked
		wr(IRQ_EN_OFFSET, 32'h0);
		want.lvd_below <= 1'b1;
		wait_for(3, 1);
		repeat (3) @(posedge aclk);
		chk(irq, 1'b0);
		wr(IRQ_EN_OFFSET, 32'h1);
		wait_for(2, 1);
		want.lvd_below <= 1'b0;
		wr(BKP_OFFSET, 32'h1);
		@(posedge aclk);
		chk(backup_reset, 1'b1);
		wr(BKP_OFFSET, 32'h0);
		@(posedge aclk);
		chk(backup_reset, 1'b0);
		brownout_threshold <= 2'($urandom);
		@(posedge aclk);
		chk(brownout_level, brownout_threshold);
		// Sources at distinct rates: every tick, every other, every tick over 128
		for (int s = 0; s < 3; s++) begin
			wr(CTRL_OFFSET, s << RTC_SEL_LSB);
			cnt = 0;
			for (int c = 0; c < 264; c++) begin
				@(posedge aclk);
				cnt += rtc_clk_en;
				slow_rc_clk_en <= c < 256;
				high_xtal_clk_en <= c < 256;
				low_xtal_clk_en <= c < 256 && c[0];
			end
			chk(cnt, s == 0 ? 256 : s == 1 ? 128 : 256 / HS_DIV);
		end
		wr(CTRL_OFFSET, 32'h140);
		chk(power_mode, PM_RUN);
		core(0);
		wait_for(12, 1);
		chk(regulator_state, REG_LOWPWR);
		wake_request <= 1'b1;
		wait_for(9, 1);
		wake_request <= 1'b0;
		wr(CTRL_OFFSET, 32'h0);
		core(1);
		wait_for(10, 1);
		chk(regulator_state, REG_FULL);
		wake_request <= 1'b1;
		wait_for(9, 1);
		wake_request <= 1'b0;
		wr(CTRL_OFFSET, 32'h8c0);
		core(0);
		wait_for(11, 1);
		chk(regulator_state, REG_OFF);
		rtc_match <= 1'b1;
		wait_for(5, 1);
		wait_for(9, 1);
		rtc_match <= 1'b0;
		wr(CTRL_OFFSET, 32'h11);
		want.por_low <= 1'b1;
		wait_for(6, 1);
		chk(backup_reset, 1'b1);
		want.por_low <= 1'b0;
		wait_for(6, 0);
		wait_for(8, 0);
		rd(CTRL_OFFSET, 32'h0, RESP_OKAY);
		want.bor_low <= 1'b1;
		wait_for(7, 1);
		chk(backup_reset, 1'b0);
		want.bor_low <= 1'b0;
		wait_for(7, 0);
		// Core reset must stand 16 cycles once the supply is back
		for (cnt = 0; cnt < 400 && core_reset; cnt++) @(posedge aclk);
		chk(cnt, 16);
		tally_and_finish();
	end
endmodule : supply_monitor_reset_ctrl_tb

// >>> dv/supply_partner.sv
// Purpose: Analog comparators and core model
// Assumes: Bench requests comparator levels and wait instructions
// Notes:   Comparator edges land off the clock, as real ones do
`timescale 1ns/1ps
module supply_partner
	import supply_monitor_pkg::*;
(
	input  wire logic  aclk,
	input  wire comp_t want,
	input  wire logic  wfi_go,
	input  wire logic  wfe_go,
	output comp_t      comp_async,
	output logic       wait_for_irq_instr,
	output logic       wait_for_event_instr
);
	// ==========================================================
	// Comparators
	// Skew of 7 ns keeps changes away from the sampling edge
	initial begin
		comp_async = '0;
		forever @(want) comp_async <= #7 want;
	end

	// ==========================================================
	// Core
	initial begin
		wait_for_irq_instr = 1'b0;
		wait_for_event_instr = 1'b0;
		forever @(posedge aclk) begin
			wait_for_irq_instr <= wfi_go;
			wait_for_event_instr <= wfe_go;
		end
	end
endmodule : supply_partner

// >>> logic/supply_monitor_pkg.sv
// Purpose: Shared constants and types for the supply monitor and reset controller
// Assumes: 32-bit AXI4-Lite register bus, 40 MHz aclk
// Notes:   Register offsets are byte addresses
package supply_monitor_pkg;

	// ==========================================================
	// Register map
	localparam logic [7:0] CTRL_OFFSET   = 8'h00;
	localparam logic [7:0] STATUS_OFFSET = 8'h04;
	localparam logic [7:0] IRQ_ST_OFFSET = 8'h08;
	localparam logic [7:0] IRQ_EN_OFFSET = 8'h0c;
	localparam logic [7:0] EDGE_OFFSET   = 8'h10;
	localparam logic [7:0] BKP_OFFSET    = 8'h14;

	// ==========================================================
	// Control field positions
	localparam int LVD_EN_BIT    = 0;
	localparam int LVD_TH_LSB    = 1;
	localparam int OVD_EN_BIT    = 4;
	localparam int OVD_TH_BIT    = 5;
	localparam int DEEP_BIT      = 6;
	localparam int STBY_BIT      = 7;
	localparam int LDO_LP_BIT    = 8;
	localparam int RTC_SEL_LSB   = 9;
	localparam int RTC_WK_EN_BIT = 11;

	localparam logic [11:0] CTRL_RESET  = 12'h000;
	localparam logic [11:0] CTRL_MASK   = 12'hfff;
	localparam logic [2:0]  LVD_TH_RESET = 3'h0;

	// Event bits: lvd edge, ovd edge, rtc wakeup
	localparam int EV_LVD = 0;
	localparam int EV_OVD = 1;
	localparam int EV_RTC = 2;
	localparam int EV_W   = 3;

	// External interrupt line numbers for detector outputs
	localparam int LVD_IRQ_LINE = 16;
	localparam int OVD_IRQ_LINE = 24;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// RTC clock source choices; high-speed crystal is divided by 128
	typedef enum logic [1:0] {
		RTC_SRC_SLOW_RC  = 2'h0,
		RTC_SRC_LOW_XTAL = 2'h1,
		RTC_SRC_HS_DIV   = 2'h2
	} rtc_src_t;
	localparam int HS_DIV = 128;

	// Regulator states
	typedef enum logic [1:0] {
		REG_FULL    = 2'h0,
		REG_LOWPWR  = 2'h1,
		REG_OFF     = 2'h3
	} regulator_t;

	// Power mode machine, Gray along run -> sleep -> deep -> standby
	typedef enum logic [1:0] {
		PM_RUN   = 2'b00,
		PM_SLEEP = 2'b01,
		PM_DEEP  = 2'b11,
		PM_STBY  = 2'b10
	} pmode_t;

	// Comparator inputs from the analog side
	typedef struct packed {
		logic por_low;
		logic bor_low;
		logic lvd_below;
		logic ovd_above;
	} comp_t;

endpackage : supply_monitor_pkg

// >>> logic/supply_monitor_reset_ctrl.sv
// Purpose: Supply detector control, chip resets and power mode entry
// Assumes: Comparator outputs asynchronous; aresetn already combined power reset
// Notes:   AXI4-Lite slave; rtc_clk_en pulses once per 128 crystal ticks on the divided source
`timescale 1ns/1ps

// Summary of operation
// - Low-voltage detector active only while its enable bit is set
// - Three-bit software field selects the low-voltage threshold level
// - Low-voltage flag shows supply above or below selected threshold
// - Low-voltage output drives interrupt line 16 on configured edge
// - Over-voltage detector active only while its enable bit is set
// - Software setting selects the over-voltage trip level
// - Over-voltage flag shows supply above or below selected threshold
// - Over-voltage output drives interrupt line 24 on configured edge
// - Whole-chip power reset while power-on comparator reports low supply
// - Brown-out reset to all but backup domain while supply low
// - Backup domain held in reset while software reset bit set
// - Regulator enabled after any reset; full, low power or off
// - RTC clock from slow RC, low-speed crystal or crystal divided
// - RTC match with wakeup enabled wakes from power saving mode
// - Core domain gets a reset sequence when its supply comes up
// - Mode bits set first, then wait instruction enters the mode
// - Over-voltage select 0 means 5V trip, 1 means 5.5V
module supply_monitor_reset_ctrl
	import supply_monitor_pkg::*;
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire comp_t       comp_async,
	input  wire logic [1:0]  brownout_threshold,
	input  wire logic        rtc_match,
	input  wire logic        wait_for_irq_instr,
	input  wire logic        wait_for_event_instr,
	input  wire logic        wake_request,
	input  wire logic        slow_rc_clk_en,
	input  wire logic        low_xtal_clk_en,
	input  wire logic        high_xtal_clk_en,
	output logic             low_volt_detect_en,
	output logic [2:0]       low_volt_threshold_sel,
	output logic             over_volt_detect_en,
	output logic             over_volt_threshold_sel,
	output logic [1:0]       brownout_level,
	output logic             low_volt_flag,
	output logic             over_volt_flag,
	output logic             low_volt_irq_line,
	output logic             over_volt_irq_line,
	output logic             power_reset,
	output logic             brownout_reset,
	output logic             backup_reset,
	output logic             core_reset,
	output logic [1:0]       regulator_state,
	output logic             rtc_clk_en,
	output logic             wakeup,
	output pmode_t           power_mode,
	output logic             irq
);
	// ==========================================================
	// Constants
	localparam int CORE_RST_CYCLES = 16;
	localparam logic [4:0] CORE_RST_LAST = 5'(CORE_RST_CYCLES - 1);
	localparam logic [6:0] DIV_LAST = 7'(HS_DIV - 1);

	// ==========================================================
	// State
	typedef struct packed {
		logic       aw_got;
		logic       w_got;
		logic [7:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic       bvalid;
		logic [1:0] bresp;
		logic       rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		logic [11:0] ctrl;
		logic [3:0] edge_rise;
		logic [3:0] edge_fall;
		logic [EV_W-1:0] irq_st;
		logic [EV_W-1:0] irq_en;
		logic       bkp_rst;
		logic       lvd_q;
		logic       ovd_q;
		logic       lvd_irq;
		logic       ovd_irq;
		logic       rtc_q;
		logic       wake_pulse;
		logic [6:0] div_cnt;
		logic       rtc_clk;
		logic [4:0] core_cnt;
		logic       core_rst;
		pmode_t     mode;
	} state_t;

	state_t st_reg;
	state_t st_next;

	// ==========================================================
	// Comparator synchronisers
	logic por_s;
	logic bor_s;
	logic lvd_s;
	logic ovd_s;

	sync2 u_sync_por (.aclk(aclk), .aresetn(aresetn), .d(comp_async.por_low),   .q(por_s));
	sync2 u_sync_bor (.aclk(aclk), .aresetn(aresetn), .d(comp_async.bor_low),   .q(bor_s));
	sync2 u_sync_lvd (.aclk(aclk), .aresetn(aresetn), .d(comp_async.lvd_below), .q(lvd_s));
	sync2 u_sync_ovd (.aclk(aclk), .aresetn(aresetn), .d(comp_async.ovd_above), .q(ovd_s));

	// ==========================================================
	// Next state
	logic        wr_fire;
	logic        rd_fire;
	logic [31:0] rd_val;
	logic        lvd_lvl;
	logic        ovd_lvl;
	logic [EV_W-1:0] ev;
	logic        chip_rst;
	logic        deep_sel;
	logic        stby_sel;

	always_comb begin
		st_next  = st_reg;
		chip_rst = por_s | bor_s;
		deep_sel = st_reg.ctrl[DEEP_BIT];
		stby_sel = st_reg.ctrl[STBY_BIT];

		// Write channel: address and data accepted in either order
		if (s_axi_awvalid && s_axi_awready) begin
			st_next.aw_got = 1'b1;
			st_next.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			st_next.w_got = 1'b1;
			st_next.wdata = s_axi_wdata;
			st_next.wstrb = s_axi_wstrb;
		end
		wr_fire = st_reg.aw_got && st_reg.w_got && !st_reg.bvalid;

		// Detector levels gated by enables
		lvd_lvl = st_reg.ctrl[LVD_EN_BIT] & lvd_s;
		ovd_lvl = st_reg.ctrl[OVD_EN_BIT] & ovd_s;
		st_next.lvd_q = lvd_lvl;
		st_next.ovd_q = ovd_lvl;
		st_next.lvd_irq = st_reg.edge_rise[0] & lvd_lvl & ~st_reg.lvd_q
			| st_reg.edge_fall[0] & ~lvd_lvl & st_reg.lvd_q;
		st_next.ovd_irq = st_reg.edge_rise[1] & ovd_lvl & ~st_reg.ovd_q
			| st_reg.edge_fall[1] & ~ovd_lvl & st_reg.ovd_q;

		// RTC wakeup only when enabled
		st_next.rtc_q = rtc_match;
		st_next.wake_pulse = st_reg.ctrl[RTC_WK_EN_BIT] & rtc_match & ~st_reg.rtc_q;

		ev = '0;
		ev[EV_LVD] = st_next.lvd_irq;
		ev[EV_OVD] = st_next.ovd_irq;
		ev[EV_RTC] = st_next.wake_pulse;

		// Clock source selector with crystal divider
		if (high_xtal_clk_en) begin
			st_next.div_cnt = (st_reg.div_cnt == DIV_LAST) ? 7'h00 : st_reg.div_cnt + 7'h01;
		end
		unique case (rtc_src_t'(st_reg.ctrl[RTC_SEL_LSB +: 2]))
			RTC_SRC_SLOW_RC:  st_next.rtc_clk = slow_rc_clk_en;
			RTC_SRC_LOW_XTAL: st_next.rtc_clk = low_xtal_clk_en;
			RTC_SRC_HS_DIV:   st_next.rtc_clk = high_xtal_clk_en && (st_reg.div_cnt == DIV_LAST);
			default:          st_next.rtc_clk = 1'b0;
		endcase

		// Register writes
		rd_val = 32'h0000_0000;
		if (wr_fire) begin
			st_next.aw_got = 1'b0;
			st_next.w_got  = 1'b0;
			st_next.bvalid = 1'b1;
			st_next.bresp  = RESP_OKAY;
			unique case (st_reg.awaddr)
				CTRL_OFFSET: begin
					if (st_reg.wstrb[0]) st_next.ctrl[7:0] = st_reg.wdata[7:0];
					if (st_reg.wstrb[1]) st_next.ctrl[11:8] = st_reg.wdata[11:8];
				end
				IRQ_ST_OFFSET: if (st_reg.wstrb[0]) st_next.irq_st = st_reg.irq_st & ~st_reg.wdata[EV_W-1:0];
				IRQ_EN_OFFSET: if (st_reg.wstrb[0]) st_next.irq_en = st_reg.wdata[EV_W-1:0];
				EDGE_OFFSET: if (st_reg.wstrb[0]) begin
					st_next.edge_rise = st_reg.wdata[3:0];
					st_next.edge_fall = st_reg.wdata[7:4];
				end
				BKP_OFFSET: if (st_reg.wstrb[0]) st_next.bkp_rst = st_reg.wdata[0];
				STATUS_OFFSET: ;
				default: st_next.bresp = RESP_SLVERR;
			endcase
		end
		// Set wins over clear
		st_next.irq_st = st_next.irq_st | ev;
		if (st_reg.bvalid && s_axi_bready) st_next.bvalid = 1'b0;

		// Register reads
		rd_fire = s_axi_arvalid && s_axi_arready;
		if (rd_fire) begin
			st_next.rvalid = 1'b1;
			st_next.rresp  = RESP_OKAY;
			unique case (s_axi_araddr)
				CTRL_OFFSET:   rd_val = {20'h0, st_reg.ctrl};
				STATUS_OFFSET: rd_val = {26'h0, st_reg.mode, por_s, bor_s,
					st_reg.ovd_q, st_reg.lvd_q};
				IRQ_ST_OFFSET: rd_val = {29'h0, st_reg.irq_st};
				IRQ_EN_OFFSET: rd_val = {29'h0, st_reg.irq_en};
				EDGE_OFFSET:   rd_val = {24'h0, st_reg.edge_fall, st_reg.edge_rise};
				BKP_OFFSET:    rd_val = {31'h0, st_reg.bkp_rst};
				default: st_next.rresp = RESP_SLVERR;
			endcase
			st_next.rdata = rd_val;
		end else if (st_reg.rvalid && s_axi_rready) begin
			st_next.rvalid = 1'b0;
		end

		// Core reset sequence after supply comes up
		if (st_reg.core_cnt != CORE_RST_LAST) begin
			st_next.core_cnt = st_reg.core_cnt + 5'h01;
		end else begin
			st_next.core_rst = 1'b0;
		end

		// Power mode machine
		unique case (st_reg.mode)
			PM_RUN: if (wait_for_irq_instr || wait_for_event_instr) begin
				st_next.mode = !deep_sel ? PM_SLEEP : (stby_sel ? PM_STBY : PM_DEEP);
			end
			PM_SLEEP, PM_DEEP: if (wake_request || st_reg.wake_pulse) st_next.mode = PM_RUN;
			PM_STBY: if (st_reg.wake_pulse) st_next.mode = PM_RUN;
		endcase

		// Brown-out clears detector setup like a power reset
		if (chip_rst) begin
			st_next.ctrl = CTRL_RESET;
			st_next.core_cnt = '0;
			st_next.core_rst = 1'b1;
			st_next.mode = PM_RUN;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_reg <= '0;
			st_reg.ctrl <= CTRL_RESET;
			st_reg.core_rst <= 1'b1;
			st_reg.mode <= PM_RUN;
		end else begin
			st_reg <= st_next;
		end
	end

	// ==========================================================
	// Outputs
	assign s_axi_awready = !st_reg.aw_got;
	assign s_axi_wready  = !st_reg.w_got;
	assign s_axi_bvalid  = st_reg.bvalid;
	assign s_axi_bresp   = st_reg.bresp;
	assign s_axi_arready = !st_reg.rvalid;
	assign s_axi_rvalid  = st_reg.rvalid;
	assign s_axi_rdata   = st_reg.rdata;
	assign s_axi_rresp   = st_reg.rresp;

	assign low_volt_detect_en      = st_reg.ctrl[LVD_EN_BIT];
	assign low_volt_threshold_sel  = st_reg.ctrl[LVD_TH_LSB +: 3];
	assign over_volt_detect_en     = st_reg.ctrl[OVD_EN_BIT];
	// 0 selects the 5V trip, 1 the 5.5V trip in the comparator
	assign over_volt_threshold_sel = st_reg.ctrl[OVD_TH_BIT];
	assign brownout_level          = brownout_threshold;
	assign low_volt_flag           = st_reg.lvd_q;
	assign over_volt_flag          = st_reg.ovd_q;
	assign low_volt_irq_line       = st_reg.lvd_irq;
	assign over_volt_irq_line      = st_reg.ovd_irq;
	assign power_reset             = por_s | !aresetn;
	assign brownout_reset          = bor_s | por_s | !aresetn;
	// Backup domain sees power reset, never brown-out
	assign backup_reset            = st_reg.bkp_rst | por_s | !aresetn;
	assign core_reset              = st_reg.core_rst;
	assign regulator_state = (st_reg.mode == PM_STBY) ? REG_OFF :
		((st_reg.mode == PM_DEEP) && st_reg.ctrl[LDO_LP_BIT]) ? REG_LOWPWR : REG_FULL;
	assign rtc_clk_en              = st_reg.rtc_clk;
	assign wakeup                  = st_reg.wake_pulse;
	assign power_mode              = st_reg.mode;
	assign irq                     = |(st_reg.irq_st & st_reg.irq_en);

	// ==========================================================
	// Assertions
	a_lvd_gated_off: assert property (@(posedge aclk) disable iff (!aresetn)
		!st_reg.ctrl[LVD_EN_BIT] |=> !low_volt_flag)
		else $error("low voltage flag set while detector disabled");
	a_ovd_gated_off: assert property (@(posedge aclk) disable iff (!aresetn)
		!st_reg.ctrl[OVD_EN_BIT] |=> !over_volt_flag)
		else $error("over voltage flag set while detector disabled");
	a_lvd_flag_follow: assert property (@(posedge aclk) disable iff (!aresetn)
		(low_volt_detect_en && lvd_s && $stable(low_volt_detect_en)) |=> low_volt_flag)
		else $error("low voltage flag missed comparator");
	a_ovd_flag_follow: assert property (@(posedge aclk) disable iff (!aresetn)
		(over_volt_detect_en && ovd_s && $stable(over_volt_detect_en)) |=> over_volt_flag)
		else $error("over voltage flag missed comparator");
	a_lvd_rise_irq: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(low_volt_flag) && $past(st_reg.edge_rise[0]) |-> low_volt_irq_line)
		else $error("low voltage rising edge gave no interrupt");
	a_ovd_no_edge: assert property (@(posedge aclk) disable iff (!aresetn)
		(st_reg.edge_rise[1] == 1'b0 && st_reg.edge_fall[1] == 1'b0) |=> !over_volt_irq_line)
		else $error("over voltage interrupt while line disabled");
	a_por_reset: assert property (@(posedge aclk) disable iff (!aresetn)
		$past(comp_async.por_low, 3) && $past(comp_async.por_low, 2) |-> power_reset)
		else $error("power reset missing during low supply");
	a_bor_reset: assert property (@(posedge aclk) disable iff (!aresetn)
		bor_s |-> brownout_reset && !(backup_reset && !st_reg.bkp_rst && !por_s))
		else $error("brown-out reset wrong or reached backup domain");
	a_bkp_hold: assert property (@(posedge aclk) disable iff (!aresetn)
		st_reg.bkp_rst |-> backup_reset)
		else $error("backup domain not held in reset");
	a_reg_run_full: assert property (@(posedge aclk) disable iff (!aresetn)
		power_mode == PM_RUN |-> regulator_state == REG_FULL)
		else $error("regulator not full power while running");
	a_wake_enable: assert property (@(posedge aclk) disable iff (!aresetn)
		wakeup |-> $past(st_reg.ctrl[RTC_WK_EN_BIT]) && $past(rtc_match))
		else $error("wakeup without enabled match");
	a_core_seq: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(bor_s) |=> core_reset [*8])
		else $error("core reset sequence too short");
	a_mode_entry: assert property (@(posedge aclk) disable iff (!aresetn || chip_rst)
		power_mode == PM_RUN && (wait_for_irq_instr || wait_for_event_instr) && !deep_sel
		|=> power_mode == PM_SLEEP)
		else $error("sleep not entered on wait instruction");
	a_ctrl_cleared: assert property (@(posedge aclk) disable iff (!aresetn)
		chip_rst |=> st_reg.ctrl == CTRL_RESET)
		else $error("detector setup not cleared by reset");

endmodule : supply_monitor_reset_ctrl

// >>> logic/sync2.sv
// Purpose: Two-flop synchroniser for one asynchronous level
// Assumes: Single clock domain aclk
// Notes:   First stage read only by second stage
`timescale 1ns/1ps
module sync2 (
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic d,
	output logic      q
);
	typedef struct packed {
		logic s1;
		logic s2;
	} sync_state_t;

	sync_state_t st_reg;
	sync_state_t st_next;

	always_comb begin
		st_next.s1 = d;
		st_next.s2 = st_reg.s1;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign q = st_reg.s2;
endmodule : sync2
